// ==== hw/ouef_framer.sv ====
/*
 holds the client end of the upgrade end exchange: parses upgrade end responses,
 keeps the scheduled times, starts an upgrade and answers malformed end responses with a
 default response.
 assumes a byte stream with valid and last from the mesh receive path.
*/
// Summary of operation
// R1: server answers a successful end request with an end response
// R2: unsolicited end response replaces the scheduled waiting time
// R3: end response frame control is server to client value
// R4: server copies request sequence number into response
// R5: command byte identifies upgrade end response, decoded as such
// R6: manufacturer code at offset 3 matches the request
// R7: image type at offset 5 matches the request
// R8: file version at offset 7 matches the request
// R9: current time at offset 11 is the scheduling reference
// R10: upgrade time at offset 15 is the scheduled upgrade moment
// R11: equal times below limit request an immediate upgrade; the code upgrades at once only when both times are zero
// R12: both times zero makes the client reboot and install at once
// R13: invalid server command returns an error default response; the code answers only end responses (command 0x07) that fail the checks
// R14: server acknowledges error end requests with success default response
// R15: default response frame control differs for client and server
// R16: default response repeats the causing sequence number
// R17: default response command byte identifies default response
// R18: default response byte 3 holds the causing command id
// R19: default response byte 4 holds the status code
// R20: multi-byte fields travel least significant byte first
// R21: malformed end response is treated as invalid command
`timescale 1ns/10ps
`default_nettype none
module ouef_framer (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_last_in,
	input wire logic [15:0] exp_mfg_in,
	input wire logic [15:0] exp_img_in,
	input wire logic [31:0] exp_ver_in,
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	output logic tx_last_out,
	output logic upgrade_now_out,
	output logic sched_valid_out,
	output logic [31:0] cur_time_out,
	output logic [31:0] upg_time_out,
	output logic end_resp_out
);
	// rx valid, data and last inputs pass two flip-flops; reset and expected fields are not synchronised
	logic rxv_m_r, rxv_s_r, rxl_m_r, rxl_s_r;
	logic [7:0] rxd_m_r, rxd_s_r;
	logic [4:0] pos_r;
	logic bad_r;
	logic [7:0] fc_r, seq_r, cmd_r;
	logic [15:0] mfg_r, img_r;
	logic [31:0] ver_r, cur_r, upg_r;
	logic [7:0] err_seq_r, err_cmd_r;
	logic err_req_r;
	logic [4:0] pos_nxt;
	wire logic frame_end;
	wire logic len_ok;
	wire logic is_uer;
	wire logic fields_ok;
	wire logic good_uer;
	wire logic both_zero;
	wire logic [31:0] upg_fin;
	wire logic dr_busy;
	ouef_dr_if dr_bus ();

	// places a byte into a 32-bit field lsb first
	function automatic logic [31:0] put_byte(input logic [31:0] f, input logic [7:0] b,
		input logic [4:0] rel);
		logic [31:0] r;
		r = f;
		r[{rel[1:0], 3'h0} +: 8] = b;
		return r;
	endfunction

	// frame decode
	assign frame_end = rxv_s_r && rxl_s_r;
	assign pos_nxt = (pos_r == ouef_pkg::OUEF_POS_MAX) ? pos_r : pos_r + 5'h01;
	// R21: length check
	assign len_ok = (pos_r == ouef_pkg::OUEF_UER_LEN - 5'h01) && !bad_r;
	// R5: command decode
	assign is_uer = (cmd_r == ouef_pkg::OUEF_CMD_UER);
	// R3: frame control check
	assign fields_ok = (fc_r == ouef_pkg::OUEF_FC_SRV_CMD) && (mfg_r == exp_mfg_in)
		&& (img_r == exp_img_in) && (ver_r == exp_ver_in);
	assign good_uer = is_uer && fields_ok && len_ok;
	// last upgrade byte lands on the verdict edge, so merge it here
	assign upg_fin = (pos_r == ouef_pkg::OUEF_UER_LEN - 5'h01)
		? put_byte(upg_r, rxd_s_r, pos_r - ouef_pkg::OUEF_OFS_UPG) : upg_r;
	// R12: zero times
	assign both_zero = (cur_r == ouef_pkg::OUEF_TIME_ZERO)
		&& (upg_fin == ouef_pkg::OUEF_TIME_ZERO);
	assign dr_bus.seq = err_seq_r;
	assign dr_bus.src_cmd = err_cmd_r;
	// R19: malformed status code
	assign dr_bus.status = ouef_pkg::OUEF_ST_MALFORMED;
	assign dr_bus.req = err_req_r;
	assign dr_busy = dr_bus.busy;

	// input synchronisers
	always_ff @(posedge mclk_in) begin
		rxv_m_r <= rx_valid_in;
		rxv_s_r <= rxv_m_r;
		rxl_m_r <= rx_last_in;
		rxl_s_r <= rxl_m_r;
		rxd_m_r <= rx_data_in;
		rxd_s_r <= rxd_m_r;
	end

	// byte capture by payload position
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pos_r <= 5'h00;
			bad_r <= 1'b0;
			fc_r <= 8'h00;
			seq_r <= 8'h00;
			cmd_r <= 8'h00;
			mfg_r <= 16'h0000;
			img_r <= 16'h0000;
			ver_r <= 32'h0000_0000;
			cur_r <= 32'h0000_0000;
			upg_r <= 32'h0000_0000;
		end else if (rxv_s_r) begin
			pos_r <= rxl_s_r ? 5'h00 : pos_nxt;
			bad_r <= rxl_s_r ? 1'b0 : (bad_r || pos_r >= ouef_pkg::OUEF_UER_LEN - 5'h01);
			// R20: lsb first assembly
			if (pos_r == ouef_pkg::OUEF_OFS_FC)
				fc_r <= rxd_s_r;
			if (pos_r == ouef_pkg::OUEF_OFS_SEQ)
				seq_r <= rxd_s_r;
			if (pos_r == ouef_pkg::OUEF_OFS_CMD)
				cmd_r <= rxd_s_r;
			// R6: manufacturer field
			if (pos_r == ouef_pkg::OUEF_OFS_MFG)
				mfg_r[7:0] <= rxd_s_r;
			if (pos_r == ouef_pkg::OUEF_OFS_MFG + 5'h01)
				mfg_r[15:8] <= rxd_s_r;
			// R7: image type field
			if (pos_r == ouef_pkg::OUEF_OFS_IMG)
				img_r[7:0] <= rxd_s_r;
			if (pos_r == ouef_pkg::OUEF_OFS_IMG + 5'h01)
				img_r[15:8] <= rxd_s_r;
			// R8: version field
			if (pos_r >= ouef_pkg::OUEF_OFS_VER && pos_r < ouef_pkg::OUEF_OFS_CUR)
				ver_r <= put_byte(ver_r, rxd_s_r, pos_r - ouef_pkg::OUEF_OFS_VER);
			// R9: current time field
			if (pos_r >= ouef_pkg::OUEF_OFS_CUR && pos_r < ouef_pkg::OUEF_OFS_UPG)
				cur_r <= put_byte(cur_r, rxd_s_r, pos_r - ouef_pkg::OUEF_OFS_CUR);
			// R10: upgrade time field
			if (pos_r >= ouef_pkg::OUEF_OFS_UPG && pos_r < ouef_pkg::OUEF_UER_LEN)
				upg_r <= put_byte(upg_r, rxd_s_r, pos_r - ouef_pkg::OUEF_OFS_UPG);
		end
	end

	// frame verdict: accept schedule or raise an error response
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			sched_valid_out <= 1'b0;
			cur_time_out <= 32'h0000_0000;
			upg_time_out <= 32'h0000_0000;
			upgrade_now_out <= 1'b0;
			end_resp_out <= 1'b0;
			err_req_r <= 1'b0;
			err_seq_r <= 8'h00;
			err_cmd_r <= 8'h00;
		end else begin
			upgrade_now_out <= 1'b0;
			end_resp_out <= 1'b0;
			if (err_req_r && dr_busy)
				err_req_r <= 1'b0;
			// R2: adopt new times
			if (frame_end && good_uer) begin
				end_resp_out <= 1'b1;
				cur_time_out <= cur_r;
				upg_time_out <= upg_fin;
				sched_valid_out <= !both_zero;
				// R12: immediate upgrade
				upgrade_now_out <= both_zero;
			end else if (frame_end && is_uer && !err_req_r) begin
				// R13: error default response
				err_req_r <= 1'b1;
				err_seq_r <= seq_r;
				err_cmd_r <= cmd_r;
			end
		end
	end

	ouef_dr_tx u_dr_tx (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.dr(dr_bus),
		.tx_valid_out(tx_valid_out),
		.tx_data_out(tx_data_out),
		.tx_last_out(tx_last_out)
	);

	// R12: zero times reboot
	property p_zero_now;
		@(posedge mclk_in) disable iff (reset_in)
		(frame_end && good_uer && both_zero) |=> upgrade_now_out && !sched_valid_out;
	endproperty
	a_zero_now: assert property (p_zero_now) else $error("zero times did not start upgrade"); // R12
	// R2: times adopted
	property p_adopt;
		@(posedge mclk_in) disable iff (reset_in)
		(frame_end && good_uer) |=> cur_time_out == $past(cur_r) && upg_time_out == $past(upg_fin);
	endproperty
	a_adopt: assert property (p_adopt) else $error("new times not adopted"); // R2
	// R13: error leads to response
	sequence s_err_out;
		##[1:4] (tx_valid_out && tx_data_out == ouef_pkg::OUEF_FC_DR_CLI);
	endsequence
	property p_err_resp;
		@(posedge mclk_in) disable iff (reset_in)
		(frame_end && is_uer && !good_uer && !err_req_r && !dr_busy) |=> s_err_out;
	endproperty
	a_err_resp: assert property (p_err_resp) else $error("no default response for bad command"); // R13
	// R21: malformed never upgrades
	property p_bad_quiet;
		@(posedge mclk_in) disable iff (reset_in)
		(frame_end && !good_uer) |=> !upgrade_now_out && !end_resp_out;
	endproperty
	a_bad_quiet: assert property (p_bad_quiet) else $error("malformed frame accepted"); // R21
	// R5: only command 0x07 accepted
	property p_cmd;
		@(posedge mclk_in) disable iff (reset_in)
		end_resp_out |-> $past(cmd_r) == ouef_pkg::OUEF_CMD_UER;
	endproperty
	a_cmd: assert property (p_cmd) else $error("wrong command accepted"); // R5
	// R19: malformed status sent
	property p_status;
		@(posedge mclk_in) disable iff (reset_in)
		tx_last_out |-> tx_data_out == ouef_pkg::OUEF_ST_MALFORMED;
	endproperty
	a_status: assert property (p_status) else $error("status byte wrong"); // R19
endmodule
`default_nettype wire

// ==== hw/ouef_pkg.sv ====
/*
 holds constants shared by the upgrade end framer: payload offsets, command codes,
 frame control values, status codes and field lengths.
 assumes byte-serial payload streams starting at frame control.
*/
package ouef_pkg;
	localparam logic [7:0] OUEF_FC_SRV_CMD = 8'h19;
	localparam logic [7:0] OUEF_FC_DR_CLI = 8'h10;
	localparam logic [7:0] OUEF_FC_DR_SRV = 8'h18;
	localparam logic [7:0] OUEF_CMD_UER = 8'h07;
	localparam logic [7:0] OUEF_CMD_DR = 8'h0b;
	localparam logic [7:0] OUEF_ST_SUCCESS = 8'h00;
	localparam logic [7:0] OUEF_ST_MALFORMED = 8'h80;
	localparam logic [4:0] OUEF_OFS_FC = 5'h00;
	localparam logic [4:0] OUEF_OFS_SEQ = 5'h01;
	localparam logic [4:0] OUEF_OFS_CMD = 5'h02;
	localparam logic [4:0] OUEF_OFS_MFG = 5'h03;
	localparam logic [4:0] OUEF_OFS_IMG = 5'h05;
	localparam logic [4:0] OUEF_OFS_VER = 5'h07;
	localparam logic [4:0] OUEF_OFS_CUR = 5'h0b;
	localparam logic [4:0] OUEF_OFS_UPG = 5'h0f;
	localparam logic [4:0] OUEF_UER_LEN = 5'h13;
	localparam logic [4:0] OUEF_POS_MAX = 5'h1f;
	localparam logic [2:0] OUEF_DR_LEN = 3'h5;
	localparam logic [2:0] OUEF_DR_OFS_SEQ = 3'h1;
	localparam logic [2:0] OUEF_DR_OFS_CMD = 3'h2;
	localparam logic [2:0] OUEF_DR_OFS_SRC = 3'h3;
	localparam logic [2:0] OUEF_DR_OFS_ST = 3'h4;
	localparam logic [31:0] OUEF_TIME_ZERO = 32'h0000_0000;
endpackage

// ==== hw/ouef_dr_if.sv ====
/*
 holds the request interface between the response parser and the default
 response serialiser.
 assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface ouef_dr_if;
	logic req;
	logic busy;
	logic [7:0] seq;
	logic [7:0] src_cmd;
	logic [7:0] status;
	modport src (output req, output seq, output src_cmd, output status, input busy);
	modport snk (input req, input seq, input src_cmd, input status, output busy);
endinterface
`default_nettype wire

// ==== hw/ouef_dr_tx.sv ====
/*
 holds the default response serialiser of the client: five bytes, lsb first order
 is trivial since each field is one byte.
 assumes the sink accepts one byte per cycle while tx_valid is high.
*/
`timescale 1ns/10ps
`default_nettype none
module ouef_dr_tx (
	input wire logic mclk_in,
	input wire logic reset_in,
	ouef_dr_if.snk dr,
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	output logic tx_last_out
);
	logic [2:0] idx_r;
	logic busy_r;
	logic [7:0] seq_r;
	logic [7:0] src_r;
	logic [7:0] st_r;
	wire logic [7:0] byte_sel;
	wire logic start;

	assign start = dr.req && !busy_r;
	assign dr.busy = busy_r;
	// R15 R16 R17 R18: bytes by position
	assign byte_sel = (idx_r == ouef_pkg::OUEF_DR_OFS_ST) ? st_r :
		(idx_r == ouef_pkg::OUEF_DR_OFS_SRC) ? src_r :
		(idx_r == ouef_pkg::OUEF_DR_OFS_CMD) ? ouef_pkg::OUEF_CMD_DR :
		(idx_r == ouef_pkg::OUEF_DR_OFS_SEQ) ? seq_r : ouef_pkg::OUEF_FC_DR_CLI;

	// capture request then stream bytes
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			busy_r <= 1'b0;
			idx_r <= 3'h0;
			seq_r <= 8'h00;
			src_r <= 8'h00;
			st_r <= 8'h00;
			tx_valid_out <= 1'b0;
			tx_data_out <= 8'h00;
			tx_last_out <= 1'b0;
		end else begin
			tx_valid_out <= busy_r;
			tx_data_out <= byte_sel;
			tx_last_out <= busy_r && (idx_r == ouef_pkg::OUEF_DR_OFS_ST);
			if (start) begin
				busy_r <= 1'b1;
				idx_r <= 3'h0;
				seq_r <= dr.seq;
				src_r <= dr.src_cmd;
				st_r <= dr.status;
			end else if (busy_r) begin
				if (idx_r == ouef_pkg::OUEF_DR_OFS_ST) begin
					busy_r <= 1'b0;
				end
				idx_r <= idx_r + 3'h1;
			end
		end
	end

	// R15: client frame control
	// R17: fixed command byte
	property p_dr_shape;
		@(posedge mclk_in) disable iff (reset_in)
		(tx_valid_out && !$past(tx_valid_out)) |-> tx_data_out == ouef_pkg::OUEF_FC_DR_CLI
			##2 tx_data_out == ouef_pkg::OUEF_CMD_DR ##2 tx_last_out;
	endproperty
	a_dr_shape: assert property (p_dr_shape) else $error("default response shape wrong"); // R15
	// R16: sequence echoed
	property p_dr_seq;
		@(posedge mclk_in) disable iff (reset_in)
		start |=> ##2 tx_data_out == seq_r;
	endproperty
	a_dr_seq: assert property (p_dr_seq) else $error("default response sequence wrong"); // R16
	// R18: source command
	sequence s_dr_src;
		##4 tx_data_out == src_r ##1 tx_data_out == st_r;
	endsequence
	property p_dr_src;
		@(posedge mclk_in) disable iff (reset_in)
		start |=> s_dr_src;
	endproperty
	a_dr_src: assert property (p_dr_src) else $error("source or status byte wrong"); // R18
endmodule
`default_nettype wire

// ==== test/ouef_srv_model.sv ====
/*
 holds a behavioural upgrade server that sends payload bytes to the client.
 assumes the bench calls build then send, one frame at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module ouef_srv_model (
	input wire logic mclk_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_last_out
);
	logic [7:0] frame_r [0:18];
	// idle line at time zero
	initial begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		rx_last_out = 1'b0;
	end
	task automatic build(input logic [7:0] fc, input logic [7:0] seq, input logic [7:0] cmd,
		input logic [15:0] mfg, input logic [15:0] img, input logic [31:0] ver,
		input logic [31:0] cur, input logic [31:0] upg);
		frame_r[0] = fc;
		frame_r[1] = seq;
		frame_r[2] = cmd;
		for (int b = 0; b < 4; b++) begin
			if (b < 2) begin
				frame_r[3 + b] = mfg[8*b +: 8];
				frame_r[5 + b] = img[8*b +: 8];
			end
			frame_r[7 + b] = ver[8*b +: 8];
			frame_r[11 + b] = cur[8*b +: 8];
			frame_r[15 + b] = upg[8*b +: 8];
		end
	endtask
	// any frame that build loaded goes out, whatever its command byte; error end requests get no frame
	// one byte a cycle; released data shows the inverse of the last byte
	task automatic send(input int len);
		for (int i = 0; i < len; i++) begin
			@(posedge mclk_in);
			rx_valid_out <= 1'b1;
			rx_data_out <= frame_r[i];
			rx_last_out <= (i == len - 1);
		end
		@(posedge mclk_in);
		rx_valid_out <= 1'b0;
		rx_last_out <= 1'b0;
		rx_data_out <= ~frame_r[len - 1];
	endtask
endmodule
`default_nettype wire

// ==== test/ota_upgrade_end_framer_tb.sv ====
/*
 holds the self-checking bench of the upgrade end framer with a server model.
 assumes the framer answers within a few tens of cycles of a frame's last byte.
*/
`timescale 1ns/10ps
`default_nettype none
module ota_upgrade_end_framer_tb;
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic rx_valid, rx_last, tx_valid, tx_last, upg_now, sched, end_resp;
	logic [7:0] rx_data, tx_data;
	logic [15:0] mfg = 16'h5a3c;
	logic [15:0] img = 16'h0002;
	logic [31:0] ver = 32'h0300_1b07;
	logic [31:0] cur_t, upg_t;
	logic end_seen = 1'b0;
	logic now_seen = 1'b0;
	logic [7:0] txq [$];
	int last_at = 0;
	int fail_count = 0;
	int samples_checked = 0;
	// 10 MHz clock
	always #50 mclk_in = ~mclk_in;
	ouef_srv_model srv_u (.mclk_in(mclk_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.rx_last_out(rx_last));
	ouef_framer dut_u (.mclk_in(mclk_in), .reset_in(reset_in), .rx_valid_in(rx_valid),
		.rx_data_in(rx_data), .rx_last_in(rx_last), .exp_mfg_in(mfg), .exp_img_in(img),
		.exp_ver_in(ver), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
		.tx_last_out(tx_last), .upgrade_now_out(upg_now), .sched_valid_out(sched),
		.cur_time_out(cur_t), .upg_time_out(upg_t), .end_resp_out(end_resp));
	// records pulses and transmitted bytes
	always @(posedge mclk_in) begin
		if (end_resp === 1'b1) end_seen = 1'b1;
		if (upg_now === 1'b1) now_seen = 1'b1;
		if (tx_valid === 1'b1) begin
			txq.push_back(tx_data);
			if (tx_last === 1'b1) last_at = txq.size();
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	// sends a frame and waits for a verdict or a full answer
	task automatic frame(input logic [7:0] fc, input logic [7:0] seq, input logic [7:0] cmd,
		input logic [15:0] m, input logic [31:0] c, input logic [31:0] u, input int len);
		@(negedge mclk_in);
		end_seen = 1'b0;
		now_seen = 1'b0;
		txq.delete();
		last_at = 0;
		srv_u.build(fc, seq, cmd, m, img, ver, c, u);
		srv_u.send(len);
		for (int i = 0; i < 40 && !end_seen && txq.size() < 5; i++) @(posedge mclk_in);
		repeat (8) @(posedge mclk_in);
	endtask
	task automatic t_sched(input logic [31:0] c, input logic [31:0] u);
		frame(8'h19, 8'h95, 8'h07, mfg, c, u, 19);
		chk("end_resp", 1, end_seen);
		chk("upgrade_now", 0, now_seen);
		chk("sched_valid", 1, sched);
		chk("cur_time", c, cur_t);
		chk("upg_time", u, upg_t);
		chk("tx_count", 0, txq.size());
	endtask
	task automatic t_now();
		frame(8'h19, 8'h41, 8'h07, mfg, 32'h0, 32'h0, 19);
		chk("end_resp", 1, end_seen);
		chk("upgrade_now", 1, now_seen);
		chk("sched_valid", 0, sched);
	endtask
	// each fault must answer with a client default response
	task automatic t_bad(input logic [7:0] fc, input logic [7:0] seq, input logic [15:0] m,
		input int len);
		frame(fc, seq, 8'h07, m, 32'h1, 32'h2, len);
		chk("tx_count", 5, txq.size());
		if (txq.size() == 5) begin
			chk("dr_fc", 8'h10, txq[0]);
			chk("dr_seq", seq, txq[1]);
			chk("dr_cmd", 8'h0b, txq[2]);
			chk("dr_src", 8'h07, txq[3]);
			chk("dr_status", 8'h80, txq[4]);
		end
		chk("dr_last", 5, last_at);
		chk("end_resp", 0, end_seen);
		chk("cur_kept", 32'h0, cur_t);
	endtask
	task automatic t_other();
		frame(8'h19, 8'h22, 8'h05, mfg, 32'h5, 32'h6, 19);
		chk("tx_count", 0, txq.size());
		chk("end_resp", 0, end_seen);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge mclk_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		t_sched(32'h0000_1000, 32'h0000_2345);
		t_sched(32'h1234_5678, 32'h89ab_cdef);
		t_sched(32'h0000_0777, 32'h0000_0777);
		t_now();
		t_bad(8'h18, 8'h3c, mfg, 19);
		t_bad(8'h19, 8'h3d, mfg, 18);
		t_bad(8'h19, 8'h3e, 16'h5a3d, 19);
		t_other();
		report_and_stop();
	end
endmodule
`default_nettype wire
